// >>> lfcq_pkg.sv
package lfcq_pkg;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int ALPHA_MANT_W = 16;
    localparam int ALPHA_SHIFT_W = 6;
    localparam int ALPHA_FRONT_W = 3;
    localparam int ALPHA_BACK_W = 4;
    localparam int BG_MANT_W = 17;
    localparam int DELTA_MANT_W = 15;
    localparam int EXP_W = 5;

    // ------------------------------------------------------------
    // exponent biases
    // ------------------------------------------------------------
    localparam int ALPHA_BIAS = 16;
    localparam int BG_BIAS = 17;
    localparam int DELTA_BIAS = 15;

    // internal signed exponent width
    localparam int SEXP_W = 8;

    // ------------------------------------------------------------
    // default output fixed-point formats
    // ------------------------------------------------------------
    localparam int ALPHA_OUT_W = 64;
    localparam int ALPHA_OUT_FRAC = 32;
    localparam int BG_OUT_W = 48;
    localparam int BG_OUT_FRAC = 48;
    localparam int DELTA_OUT_W = 46;
    localparam int DELTA_OUT_FRAC = 46;

endpackage : lfcq_pkg

// >>> lfcq_scale.sv
`timescale 1ns/10ps
`default_nettype none

module lfcq_scale #(
    parameter int MW = 16,
    parameter int OW = 64,
    parameter int FRAC = 32
) (
    // mantissa and signed power of two
    input wire logic [MW-1:0] mant_i,
    input wire logic signed [lfcq_pkg::SEXP_W-1:0] exp_i,
    // fixed-point result with FRAC fraction bits
    output logic [OW-1:0] value_o,
    output logic sat_o
);

    localparam int XW = OW + MW;

    // the shift count is a 16-bit signed sum
    if (MW < 1 || OW < MW || FRAC < 0 || FRAC > 1000 || OW > 1000)
        $error("scale format out of range");

    // ------------------------------------------------------------
    // mantissa times two to the exp, truncated, saturating
    // ------------------------------------------------------------
    always_comb begin
        logic signed [15:0] sh;
        logic [XW-1:0] wide;
        sh = 16'(exp_i) + 16'(FRAC);
        wide = {{OW{1'b0}}, mant_i};
        sat_o = 1'b0;
        if (sh >= 16'(OW)) begin
            sat_o = |mant_i;           // any bit would land above the top
            wide = '0;
        end else if (sh >= 16'sd0) begin
            wide = wide << sh;
            sat_o = |wide[XW-1:OW];
        end else begin
            wide = wide >> (-sh);      // lost bits truncate toward zero
        end
        value_o = sat_o ? {OW{1'b1}} : wide[OW-1:0];
    end

endmodule : lfcq_scale

`default_nettype wire

// >>> lfcq_top.sv
// What this block does
// - alpha equals mantissa times two to (16 minus shift plus front plus back gain).
// - alpha shift moves binary point left; third field front gain, fourth back gain.
// - beta magnitude equals mantissa times two to minus (17 plus exponent).
// - beta and gamma are stored positive; the core negates both.
// - gamma magnitude equals mantissa times two to minus (17 plus exponent).
// - delta equals mantissa times two to minus (15 plus exponent).
`timescale 1ns/10ps
`default_nettype none

module lfcq_top #(
    parameter int ALPHA_W = lfcq_pkg::ALPHA_OUT_W,
    parameter int ALPHA_FRAC = lfcq_pkg::ALPHA_OUT_FRAC,
    parameter int BG_W = lfcq_pkg::BG_OUT_W,
    parameter int BG_FRAC = lfcq_pkg::BG_OUT_FRAC,
    parameter int DELTA_W = lfcq_pkg::DELTA_OUT_W,
    parameter int DELTA_FRAC = lfcq_pkg::DELTA_OUT_FRAC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // load strobe for all coefficient fields
    input wire logic load_i,
    // alpha fields
    input wire logic [lfcq_pkg::ALPHA_MANT_W-1:0] alpha_mant_i,
    input wire logic [lfcq_pkg::ALPHA_SHIFT_W-1:0] alpha_shift_i,
    input wire logic [lfcq_pkg::ALPHA_FRONT_W-1:0] alpha_front_i,
    input wire logic [lfcq_pkg::ALPHA_BACK_W-1:0] alpha_back_i,
    // beta, gamma, delta fields
    input wire logic [lfcq_pkg::BG_MANT_W-1:0] beta_mant_i,
    input wire logic [lfcq_pkg::EXP_W-1:0] beta_exp_i,
    input wire logic [lfcq_pkg::BG_MANT_W-1:0] gamma_mant_i,
    input wire logic [lfcq_pkg::EXP_W-1:0] gamma_exp_i,
    input wire logic [lfcq_pkg::DELTA_MANT_W-1:0] delta_mant_i,
    input wire logic [lfcq_pkg::EXP_W-1:0] delta_exp_i,
    // effective coefficients
    output logic [ALPHA_W-1:0] alpha_o,
    output logic signed [BG_W:0] beta_o,
    output logic signed [BG_W:0] gamma_o,
    output logic [DELTA_W-1:0] delta_o,
    // status
    output logic valid_o,
    output logic alpha_sat_o,
    output logic zero_mant_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ALPHA_W < lfcq_pkg::ALPHA_MANT_W || ALPHA_FRAC < 0 || ALPHA_FRAC >= ALPHA_W)
        $error("alpha output format cannot hold the mantissa");
    if (BG_W < lfcq_pkg::BG_MANT_W || BG_FRAC > BG_W || BG_FRAC < 0)
        $error("beta/gamma output format too narrow");
    if (DELTA_W < lfcq_pkg::DELTA_MANT_W || DELTA_FRAC > DELTA_W || DELTA_FRAC < 0)
        $error("delta output format too narrow");

    localparam int SW = lfcq_pkg::SEXP_W;

    // ------------------------------------------------------------
    // captured fields
    // ------------------------------------------------------------
    logic [lfcq_pkg::ALPHA_MANT_W-1:0] a_mant_r, a_mant_nxt;
    logic [lfcq_pkg::ALPHA_SHIFT_W-1:0] a_shift_r, a_shift_nxt;
    logic [lfcq_pkg::ALPHA_FRONT_W-1:0] a_front_r, a_front_nxt;
    logic [lfcq_pkg::ALPHA_BACK_W-1:0] a_back_r, a_back_nxt;
    logic [lfcq_pkg::BG_MANT_W-1:0] b_mant_r, b_mant_nxt;
    logic [lfcq_pkg::EXP_W-1:0] b_exp_r, b_exp_nxt;
    logic [lfcq_pkg::BG_MANT_W-1:0] g_mant_r, g_mant_nxt;
    logic [lfcq_pkg::EXP_W-1:0] g_exp_r, g_exp_nxt;
    logic [lfcq_pkg::DELTA_MANT_W-1:0] d_mant_r, d_mant_nxt;
    logic [lfcq_pkg::EXP_W-1:0] d_exp_r, d_exp_nxt;
    logic pend_r, pend_nxt;

    // next field values on load
    always_comb begin
        a_mant_nxt = a_mant_r;
        a_shift_nxt = a_shift_r;
        a_front_nxt = a_front_r;
        a_back_nxt = a_back_r;
        b_mant_nxt = b_mant_r;
        b_exp_nxt = b_exp_r;
        g_mant_nxt = g_mant_r;
        g_exp_nxt = g_exp_r;
        d_mant_nxt = d_mant_r;
        d_exp_nxt = d_exp_r;
        pend_nxt = load_i;
        if (load_i) begin
            a_mant_nxt = alpha_mant_i;
            a_shift_nxt = alpha_shift_i;
            a_front_nxt = alpha_front_i;
            a_back_nxt = alpha_back_i;
            b_mant_nxt = beta_mant_i;
            b_exp_nxt = beta_exp_i;
            g_mant_nxt = gamma_mant_i;
            g_exp_nxt = gamma_exp_i;
            d_mant_nxt = delta_mant_i;
            d_exp_nxt = delta_exp_i;
        end
    end

    // field registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_mant_r <= '0;
            a_shift_r <= '0;
            a_front_r <= '0;
            a_back_r <= '0;
            b_mant_r <= '0;
            b_exp_r <= '0;
            g_mant_r <= '0;
            g_exp_r <= '0;
            d_mant_r <= '0;
            d_exp_r <= '0;
            pend_r <= 1'b0;
        end else begin
            a_mant_r <= a_mant_nxt;
            a_shift_r <= a_shift_nxt;
            a_front_r <= a_front_nxt;
            a_back_r <= a_back_nxt;
            b_mant_r <= b_mant_nxt;
            b_exp_r <= b_exp_nxt;
            g_mant_r <= g_mant_nxt;
            g_exp_r <= g_exp_nxt;
            d_mant_r <= d_mant_nxt;
            d_exp_r <= d_exp_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ------------------------------------------------------------
    // exponents
    // ------------------------------------------------------------
    logic signed [SW-1:0] a_exp, b_sexp, g_sexp, d_sexp;

    // shift pulls the point left, gains push it right
    always_comb begin
        a_exp = SW'(lfcq_pkg::ALPHA_BIAS) - SW'(a_shift_r)
              + SW'(a_front_r) + SW'(a_back_r);
        b_sexp = -(SW'(lfcq_pkg::BG_BIAS) + SW'(b_exp_r));
        g_sexp = -(SW'(lfcq_pkg::BG_BIAS) + SW'(g_exp_r));
        d_sexp = -(SW'(lfcq_pkg::DELTA_BIAS) + SW'(d_exp_r));
    end

    // ------------------------------------------------------------
    // scaling
    // ------------------------------------------------------------
    logic [ALPHA_W-1:0] a_val;
    logic [BG_W-1:0] b_mag, g_mag;
    logic [DELTA_W-1:0] d_val;
    logic a_sat;

    lfcq_scale #(.MW(lfcq_pkg::ALPHA_MANT_W), .OW(ALPHA_W), .FRAC(ALPHA_FRAC)) u_alpha (
        .mant_i(a_mant_r),
        .exp_i(a_exp),
        .value_o(a_val),
        .sat_o(a_sat)
    );

    lfcq_scale #(.MW(lfcq_pkg::BG_MANT_W), .OW(BG_W), .FRAC(BG_FRAC)) u_beta (
        .mant_i(b_mant_r),
        .exp_i(b_sexp),
        .value_o(b_mag),
        .sat_o()
    );

    lfcq_scale #(.MW(lfcq_pkg::BG_MANT_W), .OW(BG_W), .FRAC(BG_FRAC)) u_gamma (
        .mant_i(g_mant_r),
        .exp_i(g_sexp),
        .value_o(g_mag),
        .sat_o()
    );

    lfcq_scale #(.MW(lfcq_pkg::DELTA_MANT_W), .OW(DELTA_W), .FRAC(DELTA_FRAC)) u_delta (
        .mant_i(d_mant_r),
        .exp_i(d_sexp),
        .value_o(d_val),
        .sat_o()
    );

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic [ALPHA_W-1:0] alpha_r, alpha_nxt;
    logic signed [BG_W:0] beta_r, beta_nxt, gamma_r, gamma_nxt;
    logic [DELTA_W-1:0] delta_r, delta_nxt;
    logic valid_r, valid_nxt, asat_r, asat_nxt, zero_r, zero_nxt;

    // update coefficients one cycle after a load
    always_comb begin
        alpha_nxt = alpha_r;
        beta_nxt = beta_r;
        gamma_nxt = gamma_r;
        delta_nxt = delta_r;
        asat_nxt = asat_r;
        zero_nxt = zero_r;
        valid_nxt = pend_r;
        if (pend_r) begin
            alpha_nxt = a_val;
            beta_nxt = -$signed({1'b0, b_mag});
            gamma_nxt = -$signed({1'b0, g_mag});
            delta_nxt = d_val;
            asat_nxt = a_sat;
            zero_nxt = ~|a_mant_r | ~|b_mant_r | ~|g_mant_r | ~|d_mant_r;
        end
    end

    // output registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alpha_r <= '0;
            beta_r <= '0;
            gamma_r <= '0;
            delta_r <= '0;
            valid_r <= 1'b0;
            asat_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            alpha_r <= alpha_nxt;
            beta_r <= beta_nxt;
            gamma_r <= gamma_nxt;
            delta_r <= delta_nxt;
            valid_r <= valid_nxt;
            asat_r <= asat_nxt;
            zero_r <= zero_nxt;
        end
    end

    assign alpha_o = alpha_r;
    assign beta_o = beta_r;
    assign gamma_o = gamma_r;
    assign delta_o = delta_r;
    assign valid_o = valid_r;
    assign alpha_sat_o = asat_r;
    assign zero_mant_o = zero_r;

endmodule : lfcq_top

`default_nettype wire

// >>> lfcq_top_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lfcq_top_checker (
    // clock, reset, strobe
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    // coefficient fields
    input wire logic [15:0] alpha_mant_i,
    input wire logic [5:0] alpha_shift_i,
    input wire logic [2:0] alpha_front_i,
    input wire logic [3:0] alpha_back_i,
    input wire logic [16:0] beta_mant_i,
    input wire logic [4:0] beta_exp_i,
    input wire logic [16:0] gamma_mant_i,
    input wire logic [4:0] gamma_exp_i,
    input wire logic [14:0] delta_mant_i,
    input wire logic [4:0] delta_exp_i,
    // coefficients and status
    input wire logic [63:0] alpha_o,
    input wire logic signed [48:0] beta_o,
    input wire logic signed [48:0] gamma_o,
    input wire logic [45:0] delta_o,
    input wire logic valid_o,
    input wire logic alpha_sat_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // answer two edges after the load edge
    sequence s_answer;
        ##2 valid_o;
    endsequence
    // timing of the update pulse
    chk_valid_timing: assert property (load_i |-> s_answer)
        else $error("valid missing after load");
    chk_valid_cause: assert property (valid_o |-> $past(load_i, 2))
        else $error("valid without load");
    // alpha in range and saturated
    chk_alpha_value: assert property (valid_o && $past(alpha_shift_i, 2) <= 48
        && $past(alpha_shift_i, 2) >= $past(alpha_front_i, 2) + $past(alpha_back_i, 2)
        |-> alpha_o == {48'h0, $past(alpha_mant_i, 2)} << (48 - $past(alpha_shift_i, 2)
        + $past(alpha_front_i, 2) + $past(alpha_back_i, 2)))
        else $error("alpha value wrong");
    chk_alpha_sat: assert property (valid_o && $past(alpha_shift_i, 2) == 0
        && $past(alpha_mant_i, 2) != 0
        && $past(alpha_front_i, 2) + $past(alpha_back_i, 2) >= 16
        |-> alpha_sat_o && &alpha_o)
        else $error("alpha not saturated");
    // negated magnitudes and delta
    chk_beta_value: assert property (valid_o |-> beta_o ==
        -$signed({32'h0, $past(beta_mant_i, 2)} << (31 - $past(beta_exp_i, 2))))
        else $error("beta value wrong");
    chk_gamma_value: assert property (valid_o |-> gamma_o ==
        -$signed({32'h0, $past(gamma_mant_i, 2)} << (31 - $past(gamma_exp_i, 2))))
        else $error("gamma value wrong");
    chk_delta_value: assert property (valid_o |-> delta_o ==
        {31'h0, $past(delta_mant_i, 2)} << (31 - $past(delta_exp_i, 2)))
        else $error("delta value wrong");
    // coefficients hold between updates
    chk_hold_value: assert property (!valid_o |-> $stable(alpha_o) && $stable(beta_o)
        && $stable(gamma_o) && $stable(delta_o))
        else $error("coefficient changed without valid");
endmodule : lfcq_top_checker

bind lfcq_top lfcq_top_checker u_chk (.clk_i, .rstn_i, .load_i, .alpha_mant_i,
    .alpha_shift_i, .alpha_front_i, .alpha_back_i, .beta_mant_i, .beta_exp_i,
    .gamma_mant_i, .gamma_exp_i, .delta_mant_i, .delta_exp_i, .alpha_o, .beta_o,
    .gamma_o, .delta_o, .valid_o, .alpha_sat_o);
`default_nettype wire

// >>> lfcq_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lfcq_top_tb;
    // stimulus
    logic clk_i = '0;
    logic rstn_i = '0;
    logic load_i = '0;
    logic [15:0] alpha_mant_i = '0;
    logic [5:0] alpha_shift_i = '0;
    logic [2:0] alpha_front_i = '0;
    logic [3:0] alpha_back_i = '0;
    logic [16:0] beta_mant_i = '0;
    logic [4:0] beta_exp_i = '0;
    logic [16:0] gamma_mant_i = '0;
    logic [4:0] gamma_exp_i = '0;
    logic [14:0] delta_mant_i = '0;
    logic [4:0] delta_exp_i = '0;
    // observed
    logic [63:0] alpha_o;
    logic signed [48:0] beta_o;
    logic signed [48:0] gamma_o;
    logic [45:0] delta_o;
    logic valid_o;
    logic alpha_sat_o;
    logic zero_mant_o;
    int fail_count = 0;
    int total_checks = 0;

    // 50 mhz clock
    initial forever #10 clk_i = ~clk_i;

    lfcq_top dut (.clk_i, .rstn_i, .load_i, .alpha_mant_i, .alpha_shift_i, .alpha_front_i,
        .alpha_back_i, .beta_mant_i, .beta_exp_i, .gamma_mant_i, .gamma_exp_i,
        .delta_mant_i, .delta_exp_i, .alpha_o, .beta_o, .gamma_o, .delta_o, .valid_o,
        .alpha_sat_o, .zero_mant_o);

    // compare and count
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // set all fields at a rising edge
    task automatic put(input logic [15:0] am, input logic [5:0] as, input logic [2:0] af,
        input logic [3:0] ab, input logic [16:0] bm, input logic [4:0] be,
        input logic [16:0] gm, input logic [4:0] ge, input logic [14:0] dm,
        input logic [4:0] de);
        alpha_mant_i <= am;
        alpha_shift_i <= as;
        alpha_front_i <= af;
        alpha_back_i <= ab;
        beta_mant_i <= bm;
        beta_exp_i <= be;
        gamma_mant_i <= gm;
        gamma_exp_i <= ge;
        delta_mant_i <= dm;
        delta_exp_i <= de;
    endtask : put

    // expected coefficients from the held fields
    task automatic expect_all();
        logic [127:0] w;
        int amt;
        logic zm;
        amt = 48 - alpha_shift_i + alpha_front_i + alpha_back_i;
        zm = (alpha_mant_i == '0) || (beta_mant_i == '0)
            || (gamma_mant_i == '0) || (delta_mant_i == '0);
        check("zero_mant", 64'(zero_mant_o), 64'(zm));
        w = (amt < 0) ? 128'(alpha_mant_i) >> -amt : 128'(alpha_mant_i) << amt;
        check("alpha_sat", 64'(alpha_sat_o), 64'(w[127:64] != 0));
        check("alpha", alpha_o, (w[127:64] != 0) ? '1 : w[63:0]);
        check("beta", 64'(beta_o), -(64'(beta_mant_i) << (31 - beta_exp_i)));
        check("gamma", 64'(gamma_o), -(64'(gamma_mant_i) << (31 - gamma_exp_i)));
        check("delta", 64'(delta_o), 64'(delta_mant_i) << (31 - delta_exp_i));
    endtask : expect_all

    // bounded wait for the update pulse
    task automatic wait_valid();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            #1;
            if (valid_o === 1'h1) return;
        end
        fail_count++;
        results();
    endtask : wait_valid

    // one load pulse, then compare
    task automatic run();
        load_i <= 1'h1;
        @(posedge clk_i);
        load_i <= '0;
        wait_valid();
        expect_all();
    endtask : run

    // main sequence
    initial begin
        int n;
        n = 0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'h1;
        @(posedge clk_i);
        put(16'hd0a8, 6'h06, '0, '0, 17'h1250b, 5'h0d,
            17'h13abb, 5'h0d, 15'h420a, 5'h08);
        run();
        @(posedge clk_i);
        put(16'hffff, '0, 3'h7, 4'hf, 17'h1ffff, '0, 17'h00001, 5'h1f, 15'h7fff, '0);
        run();
        @(posedge clk_i);
        put(16'h0001, '0, 3'h7, 4'h3, 17'h00001, 5'h1f, 17'h1ffff, 5'h1f, 15'h0001, 5'h1f);
        run();
        @(posedge clk_i);
        put(16'h8000, 6'h3f, '0, '0, '0, '0, '0, '0, '0, '0);
        run();
        // back-to-back loads
        @(posedge clk_i);
        put(16'hd0a8, 6'h06, '0, '0, 17'h1250b, 5'h0d, 17'h13abb, 5'h0d, 15'h420a, 5'h08);
        load_i <= 1'h1;
        @(posedge clk_i);
        put(16'h1234, 6'h20, 3'h2, 4'h1, 17'h0abcd, 5'h03, 17'h00777, 5'h11, 15'h0123, 5'h02);
        @(posedge clk_i);
        load_i <= '0;
        // first pulse already stands after this edge
        repeat (4) begin
            #1;
            if (valid_o === 1'h1) n++;
            @(posedge clk_i);
        end
        check("valid_count", 64'(n), 64'h2);
        expect_all();
        // reset in mid-run clears outputs
        @(posedge clk_i);
        rstn_i <= '0;
        @(posedge clk_i);
        check("reset_alpha", alpha_o, '0);
        check("reset_beta", 64'(beta_o), '0);
        check("reset_gamma", 64'(gamma_o), '0);
        check("reset_delta", 64'(delta_o), '0);
        check("reset_valid", 64'(valid_o), '0);
        rstn_i <= 1'h1;
        run();
        results();
    end
endmodule : lfcq_top_tb
`default_nettype wire
